// [verilog/scs_pkg.sv]
package scs_pkg;
  // Resolution and result codes
  localparam int RES_BITS = 18;
  localparam logic [17:0] CODE_ZERO = 18'h00000;
  localparam logic [17:0] CODE_POS_MAX = 18'h1FFFF;
  localparam logic [17:0] CODE_NEG_MAX = 18'h20000;
  localparam logic [17:0] RESULT_RST = 18'h00000;
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_RATE_KSPS = 1000;
  // Longest allowed cycle for one sample, rounded down
  localparam int SAMPLE_PERIOD_CYC = (CLK_MHZ * 1000) / SAMPLE_RATE_KSPS;
  // Settling of each bit step in sys_clk_i cycles, counted from zero
  localparam logic [2:0] STEP_CYC = 3'h2;
  localparam logic [4:0] BIT_MSB = 5'h11;

  typedef enum logic [2:0] {
    SCS_ACQ = 3'b000,
    SCS_OPEN = 3'b001,
    SCS_HOLD = 3'b010,
    SCS_TRIAL = 3'b011,
    SCS_DONE = 3'b100
  } scs_state_type;
endpackage : scs_pkg

// [verilog/scs_sequencer.sv]
`timescale 1ns/1ps
module scs_sequencer #(
  parameter int RES = 18
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic convert_start_i,
  input wire logic serial_in_mode_select_i,
  input wire logic busy_enable_i,
  input wire logic comp_high_i,
  input wire logic over_range_i,
  input wire logic under_range_i,
  output logic pos_sample_switch_o,
  output logic neg_sample_switch_o,
  output logic array_to_input_o,
  output logic [17:0] dac_bits_o,
  output logic converting_o,
  output logic powered_down_o,
  output logic busy_o,
  output logic start_bit_o,
  output logic chain_mode_o,
  output logic [17:0] result_o,
  output logic result_valid_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] cnv_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic [1:0] ovr_sync_reg;
  logic [1:0] und_sync_reg;
  logic cnv_prev_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnv_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      ovr_sync_reg <= 2'h0;
      und_sync_reg <= 2'h0;
      cnv_prev_reg <= 1'b0;
    end else begin
      cnv_sync_reg <= {cnv_sync_reg[0], convert_start_i};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_in_mode_select_i};
      cmp_sync_reg <= {cmp_sync_reg[0], comp_high_i};
      ovr_sync_reg <= {ovr_sync_reg[0], over_range_i};
      und_sync_reg <= {und_sync_reg[0], under_range_i};
      cnv_prev_reg <= cnv_sync_reg[1];
    end
  end
  wire cnv_rise = cnv_sync_reg[1] & ~cnv_prev_reg;

  // ****************************************
  // Sequencer
  // ****************************************
  scs_pkg::scs_state_type state_reg, state_next;
  logic [4:0] bit_reg, bit_next;
  logic [2:0] step_reg, step_next;
  logic [17:0] trial_reg, trial_next;
  logic [17:0] result_reg, result_next;
  logic chain_reg, chain_next;
  logic busy_reg, busy_next;
  logic valid_reg, valid_next;

  wire start_ok = cnv_rise & (state_reg == scs_pkg::SCS_ACQ);
  wire step_done = (step_reg == scs_pkg::STEP_CYC);
  wire last_bit = (bit_reg == 5'h00);
  // Weight of the element under trial
  wire [17:0] weight = 18'h00001 << bit_reg;
  // Trial holds offset binary; flip the MSB for two's complement
  wire [17:0] kept = cmp_sync_reg[1] ? trial_reg : (trial_reg & ~weight);
  wire [17:0] raw_code = {~trial_reg[17], trial_reg[16:0]};
  wire [17:0] sat_code = ovr_sync_reg[1] ? scs_pkg::CODE_POS_MAX :
                         und_sync_reg[1] ? scs_pkg::CODE_NEG_MAX : raw_code;

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    step_next = step_reg;
    trial_next = trial_reg;
    result_next = result_reg;
    chain_next = chain_reg;
    busy_next = 1'b0;
    valid_next = 1'b0;
    case (state_reg)
      scs_pkg::SCS_ACQ: begin
        if (start_ok) begin
          chain_next = ~sdi_sync_reg[1];
          state_next = scs_pkg::SCS_OPEN;
        end
      end
      scs_pkg::SCS_OPEN: begin
        state_next = scs_pkg::SCS_HOLD;
      end
      scs_pkg::SCS_HOLD: begin
        bit_next = scs_pkg::BIT_MSB;
        trial_next = 18'h20000;
        step_next = 3'h0;
        state_next = scs_pkg::SCS_TRIAL;
      end
      scs_pkg::SCS_TRIAL: begin
        step_next = step_reg + 3'h1;
        if (step_done) begin
          step_next = 3'h0;
          if (last_bit) begin
            trial_next = kept;
            state_next = scs_pkg::SCS_DONE;
          end else begin
            trial_next = kept | (weight >> 1);
            bit_next = bit_reg - 5'h01;
          end
        end
      end
      scs_pkg::SCS_DONE: begin
        // Overrange is tested first so a clipped input never wraps
        result_next = sat_code;
        busy_next = busy_enable_i;
        valid_next = 1'b1;
        state_next = scs_pkg::SCS_ACQ;
      end
      default: begin
        state_next = scs_pkg::SCS_ACQ;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= scs_pkg::SCS_ACQ;
      bit_reg <= 5'h00;
      step_reg <= 3'h0;
      trial_reg <= 18'h00000;
      result_reg <= scs_pkg::RESULT_RST;
      chain_reg <= 1'b0;
      busy_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      step_reg <= step_next;
      trial_reg <= trial_next;
      result_reg <= result_next;
      chain_reg <= chain_next;
      busy_reg <= busy_next;
      valid_reg <= valid_next;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  wire acq_n = (state_next != scs_pkg::SCS_ACQ);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pos_sample_switch_o <= 1'b1;
      neg_sample_switch_o <= 1'b1;
      array_to_input_o <= 1'b1;
      dac_bits_o <= 18'h00000;
      converting_o <= 1'b0;
      powered_down_o <= 1'b1;
    end else begin
      pos_sample_switch_o <= ~acq_n;
      neg_sample_switch_o <= ~acq_n;
      // Array leaves inputs one cycle after switches open, freezing the sample
      array_to_input_o <= (state_next == scs_pkg::SCS_ACQ) ||
                          (state_next == scs_pkg::SCS_OPEN);
      dac_bits_o <= (state_next == scs_pkg::SCS_TRIAL) ? trial_next : 18'h00000;
      converting_o <= acq_n;
      powered_down_o <= ~acq_n;
    end
  end
  assign busy_o = busy_reg;
  assign start_bit_o = busy_reg;
  assign chain_mode_o = chain_reg;
  assign result_o = result_reg;
  assign result_valid_o = valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  // Take to valid: open, hold, three cycles per bit, done, then the valid flop
  localparam int CONV_CYC = 3 + RES * 3 + 1;
  sequence s_start;
    start_ok;
  endsequence
  sequence s_open_then_ground;
    ##1 (state_reg == scs_pkg::SCS_OPEN && !pos_sample_switch_o && array_to_input_o)
    ##1 (!pos_sample_switch_o && !array_to_input_o);
  endsequence
  AST_OPEN_FIRST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_start |-> s_open_then_ground) else $error("switch order wrong");
  AST_DONE_BOUND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_start |-> ##[1:CONV_CYC] valid_reg) else $error("conversion too long");
  AST_ACQ_AFTER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_reg |-> state_reg == scs_pkg::SCS_ACQ) else $error("not back in acquisition");
  AST_PD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == scs_pkg::SCS_ACQ && $past(state_reg) == scs_pkg::SCS_ACQ)
    |-> powered_down_o) else $error("not powered down");
  AST_HOLD_RES: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !valid_reg |-> $stable(result_reg)) else $error("result changed");
  AST_OVR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == scs_pkg::SCS_DONE && ovr_sync_reg[1]) |=> result_reg == 18'h1FFFF)
    else $error("overrange not saturated");
  AST_UND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == scs_pkg::SCS_DONE && !ovr_sync_reg[1] && und_sync_reg[1])
    |=> result_reg == 18'h20000) else $error("underrange not saturated");
  AST_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_ok |=> chain_reg == !$past(sdi_sync_reg[1])) else $error("mode latch wrong");
  AST_MSB_FIRST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == scs_pkg::SCS_HOLD) |=> bit_reg == 5'h11 && trial_reg == 18'h20000)
    else $error("search not MSB first");
  AST_BUSY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    busy_reg |-> valid_reg) else $error("busy without result");
endmodule : scs_sequencer

// [tb/scs_host_model.sv]
`timescale 1ns/1ps
// ****************
// Host and front end
// ****************
module scs_host_model (
  input wire logic sys_clk_i,
  input wire logic start_req_i,
  input wire logic array_to_input_i,
  input wire logic [17:0] level_i,
  input wire logic [17:0] dac_bits_i,
  output logic convert_start_o,
  output logic comp_high_o
);
  logic [17:0] held_reg = 18'h20000;
  logic [2:0] high_reg = 3'h0;
  // Arrays track the input only while connected, so late input changes cannot leak in
  always @(posedge sys_clk_i) begin
    if (array_to_input_i) begin
      held_reg <= level_i;
    end
    if (start_req_i) begin
      high_reg <= 3'h4;
    end else if (high_reg != 3'h0) begin
      high_reg <= high_reg - 3'h1;
    end
  end
  assign convert_start_o = (high_reg != 3'h0);
  assign comp_high_o = (dac_bits_i <= held_reg);
endmodule : scs_host_model

// [tb/sar_conversion_sequencer_test.sv]
`timescale 1ns/1ps
module sar_conversion_sequencer_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic md = 1'b1;
  logic be = 1'b0;
  logic ov = 1'b0;
  logic un = 1'b0;
  logic [17:0] lvl = 18'h20000;
  logic cs, comp, psw, nsw, ai, cv, pd, bz, sb, cm, rv;
  logic [17:0] dac, res;
  int fail_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  scs_sequencer uut (.sys_clk_i(clk), .rst_i(rst), .convert_start_i(cs),
    .serial_in_mode_select_i(md), .busy_enable_i(be), .comp_high_i(comp),
    .over_range_i(ov), .under_range_i(un), .pos_sample_switch_o(psw),
    .neg_sample_switch_o(nsw), .array_to_input_o(ai), .dac_bits_o(dac),
    .converting_o(cv), .powered_down_o(pd), .busy_o(bz), .start_bit_o(sb),
    .chain_mode_o(cm), .result_o(res), .result_valid_o(rv));
  scs_host_model host (.sys_clk_i(clk), .start_req_i(req), .array_to_input_i(ai),
    .level_i(lvl), .dac_bits_i(dac), .convert_start_o(cs), .comp_high_o(comp));
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  // Input is disturbed and a restart may be tried mid-search; both must be ignored
  task automatic convert(input logic [17:0] v, input logic m, input logic b, input logic o,
    input logic u, input logic again, output logic [17:0] r);
    int n;
    int t_sw;
    int t_ai;
    logic pd_ok;
    @(posedge clk);
    lvl <= v;
    md <= m;
    be <= b;
    ov <= o;
    un <= u;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    t_sw = 0;
    t_ai = 0;
    pd_ok = 1'b1;
    while (rv !== 1'b1 && n < 200) begin
      @(posedge clk);
      if (n == 11) lvl <= ~v;
      if (n == 11) req <= again;
      if (n == 12) req <= 1'b0;
      #1;
      n++;
      if (psw === 1'b0 && nsw === 1'b0 && t_sw == 0) t_sw = n;
      if (ai === 1'b0 && t_ai == 0) t_ai = n;
      if (pd !== ~cv) pd_ok = 1'b0;
    end
    if (rv !== 1'b1) begin
      fail_count++;
      results();
    end
    r = res;
    check("switch_order", {17'h0, t_sw > 0 && t_sw < t_ai}, 18'h1);
    check("sample_time", {17'h0, n <= 125}, 18'h1);
    check("power_down", {17'h0, pd_ok}, 18'h1);
    check("dac_idle", dac, 18'h00000);
    check("busy", {17'h0, bz}, {17'h0, b});
    check("start_bit", {17'h0, sb}, {17'h0, b});
    check("chain_mode", {17'h0, cm}, {17'h0, ~m});
  endtask : convert
  // ****************
  // Scenarios
  // ****************
  task automatic test_reset();
    repeat (11) @(posedge clk);
    #1;
    check("rst_switch", {17'h0, psw & nsw & ai}, 18'h1);
    check("rst_dac", dac, 18'h00000);
    check("rst_idle", {17'h0, pd & ~bz & ~rv}, 18'h1);
    check("rst_result", res, 18'h00000);
    @(posedge clk);
    rst <= 1'b0;
    $display("test_reset done");
  endtask : test_reset
  task automatic test_codes();
    logic [17:0] v [5] = '{18'h20000, 18'h1FFFF, 18'h00000, 18'h20001, 18'h3FFFF};
    logic [17:0] r;
    for (int i = 0; i < 5; i++) begin
      convert(v[i], i[0], ~i[0], 1'b0, 1'b0, 1'b0, r);
      check("code", r, v[i] ^ 18'h20000);
    end
    $display("test_codes done");
  endtask : test_codes
  task automatic test_range();
    logic [17:0] r;
    convert(18'h20000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, r);
    check("over", r, 18'h1FFFF);
    convert(18'h3FFFF, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, r);
    check("under", r, 18'h20000);
    convert(18'h20000, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, r);
    check("over_wins", r, 18'h1FFFF);
    $display("test_range done");
  endtask : test_range
  task automatic test_refuse();
    logic [17:0] r;
    logic bad;
    bad = 1'b0;
    convert(18'h2ABCD, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, r);
    check("refused_start", r, 18'h0ABCD);
    repeat (40) begin
      @(posedge clk);
      #1;
      if (rv !== 1'b0 || res !== r) bad = 1'b1;
    end
    check("held", {17'h0, bad}, 18'h0);
    $display("test_refuse done");
  endtask : test_refuse
  initial begin
    test_reset();
    test_codes();
    test_range();
    test_refuse();
    results();
  end
endmodule : sar_conversion_sequencer_test
